// *** loem_consts.svh ***
`ifndef LOEM_CONSTS_SVH
`define LOEM_CONSTS_SVH
// system clock and tick base
`define LOEM_CLK_HZ 125000000
`define LOEM_TICK_MS 100
`define LOEM_TICK_CYC ((`LOEM_CLK_HZ / 1000) * `LOEM_TICK_MS)
// errored-frame window, in ticks
`define LOEM_EF_WIN_DEF 16'h000a
`define LOEM_EF_WIN_MIN 16'h000a
`define LOEM_EF_WIN_MAX 16'h0258
// errored-frame threshold default
`define LOEM_EF_THR_DEF 32'h0000_0001
// ticks per second for errored-second detection
`define LOEM_TICKS_PER_SEC 4'ha
`endif

// *** loem_pkg.sv ***
package loem_pkg;
	// per-type event stamp and counters
	typedef struct packed {
		logic [15:0] stamp;
		logic [31:0] period_errs;
		logic [63:0] total_errs;
		logic [31:0] events;
	} loem_frame_stat_s;
	typedef struct packed {
		logic [15:0] stamp;
		logic [63:0] period_errs;
		logic [63:0] total_errs;
		logic [31:0] events;
	} loem_sym_stat_s;
	typedef struct packed {
		logic [15:0] stamp;
		logic [15:0] period_errs;
		logic [31:0] total_errs;
		logic [31:0] events;
	} loem_sec_stat_s;
	// configuration carried as one group
	typedef struct packed {
		logic [15:0] ef_window;
		logic [31:0] ef_thresh;
		logic [31:0] fp_window;
		logic [31:0] fp_thresh;
		logic [63:0] sp_window;
		logic [63:0] sp_thresh;
		logic [15:0] es_window;
		logic [15:0] es_thresh;
	} loem_cfg_s;
	// what the remote peer reported, as one group
	typedef struct packed {
		logic [15:0] seq;
		loem_frame_stat_s ef;
		loem_frame_stat_s fp;
		loem_sym_stat_s sp;
		loem_sec_stat_s es;
	} loem_report_s;
endpackage : loem_pkg

// *** loem_tick.sv ***
`timescale 1ns/1ns
`include "loem_consts.svh"
module loem_tick
	import loem_pkg::*;
#(
	parameter int TICK_CYC = `LOEM_TICK_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// 100 ms enable and timestamp
	output logic o_tick,
	output logic [15:0] o_now
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
		logic [15:0] now;
	} loem_tick_st_s;
	loem_tick_st_s st_ff;
	loem_tick_st_s nxt_st;

	// divider makes one pulse per tick; the stamp wraps at 16 bits
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt >= 32'(TICK_CYC - 1)) begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
			nxt_st.now = st_ff.now + 16'h0001;
		end else begin
			nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_tick = st_ff.tick;
	assign o_now = st_ff.now;
endmodule : loem_tick

// *** loem_monitor.sv ***
`timescale 1ns/1ns
`include "loem_consts.svh"
module loem_monitor
	import loem_pkg::*;
#(
	parameter int TICK_CYC = `LOEM_TICK_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// sublayer reset and software clear, same clock domain
	input wire logic i_oam_reset,
	input wire logic i_clear,
	// receive path strobes, one per cycle at most
	input wire logic i_frame_rx,
	input wire logic i_frame_err,
	input wire logic i_symbol_rx,
	input wire logic i_symbol_err,
	// configuration
	input wire loem_cfg_s i_cfg,
	// peer report: new event tlv seen, sequence and fields
	input wire logic i_remote_valid,
	input wire loem_report_s i_remote,
	// local state
	output loem_frame_stat_s o_ef,
	output loem_frame_stat_s o_fp,
	output loem_sym_stat_s o_sp,
	output loem_sec_stat_s o_es,
	output logic [15:0] o_ef_window,
	// one-cycle event pulses, {es, sp, fp, ef}
	output logic [3:0] o_event,
	// remote state
	output loem_report_s o_remote
);
	typedef struct packed {
		loem_frame_stat_s ef;
		loem_frame_stat_s fp;
		loem_sym_stat_s sp;
		loem_sec_stat_s es;
		logic [15:0] ef_ticks;
		logic [31:0] fp_frames;
		logic [63:0] sp_syms;
		logic [15:0] es_ticks;
		logic [3:0] sec_ticks;
		logic sec_err;
		logic [3:0] evt;
		logic [15:0] win;
		loem_report_s rem;
	} loem_mon_st_s;
	loem_mon_st_s st_ff;
	loem_mon_st_s nxt_st;

	logic tick;
	logic [15:0] now;
	logic [15:0] ef_win;
	logic [31:0] ef_cnt;
	logic [31:0] fp_cnt;
	logic [63:0] sp_cnt;
	logic [15:0] es_cnt;
	logic sec_end;
	logic sec_bad;

	// shared 100 ms time base
	loem_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.o_tick(tick),
		.o_now(now)
	);

	// window clamped into the legal one second to one minute range
	always_comb begin
		if (i_cfg.ef_window < `LOEM_EF_WIN_MIN) begin
			ef_win = `LOEM_EF_WIN_MIN;
		end else if (i_cfg.ef_window > `LOEM_EF_WIN_MAX) begin
			ef_win = `LOEM_EF_WIN_MAX;
		end else begin
			ef_win = i_cfg.ef_window;
		end
	end

	// period counts including this cycle's strobe
	assign ef_cnt = st_ff.ef.period_errs + {31'h0, i_frame_err};
	assign fp_cnt = st_ff.fp.period_errs + {31'h0, i_frame_err};
	assign sp_cnt = st_ff.sp.period_errs + {63'h0, i_symbol_err};
	assign sec_end = tick && (st_ff.sec_ticks == `LOEM_TICKS_PER_SEC - 4'h1);
	assign sec_bad = st_ff.sec_err || i_frame_err;
	assign es_cnt = st_ff.es.period_errs + {15'h0, sec_end && sec_bad};

	always_comb begin
		nxt_st = st_ff;
		nxt_st.evt = 4'h0;
		// lifetime totals keep running across windows
		nxt_st.ef.total_errs = st_ff.ef.total_errs
			+ {63'h0, i_frame_err};
		nxt_st.fp.total_errs = st_ff.fp.total_errs
			+ {63'h0, i_frame_err};
		nxt_st.sp.total_errs = st_ff.sp.total_errs
			+ {63'h0, i_symbol_err};
		nxt_st.ef.period_errs = ef_cnt;
		nxt_st.fp.period_errs = fp_cnt;
		nxt_st.sp.period_errs = sp_cnt;
		nxt_st.es.period_errs = es_cnt;

		// errored-frame window, time based
		if (tick) begin
			if (st_ff.ef_ticks + 16'h0001 >= ef_win) begin
				nxt_st.ef_ticks = '0;
				nxt_st.ef.period_errs = '0;
				if (ef_cnt >= i_cfg.ef_thresh) begin
					nxt_st.evt[0] = 1'b1;
					nxt_st.ef.stamp = now;
					nxt_st.ef.events = st_ff.ef.events + 32'h0000_0001;
				end
			end else begin
				nxt_st.ef_ticks = st_ff.ef_ticks + 16'h0001;
			end
		end

		// frame-period window, counted in received frames
		if (i_frame_rx) begin
			if (st_ff.fp_frames + 32'h0000_0001 >= i_cfg.fp_window) begin
				nxt_st.fp_frames = '0;
				nxt_st.fp.period_errs = '0;
				if (fp_cnt >= i_cfg.fp_thresh) begin
					nxt_st.evt[1] = 1'b1;
					nxt_st.fp.stamp = now;
					nxt_st.fp.events = st_ff.fp.events + 32'h0000_0001;
				end
			end else begin
				nxt_st.fp_frames = st_ff.fp_frames + 32'h0000_0001;
			end
		end

		// symbol window, counted in received symbols
		if (i_symbol_rx) begin
			if (st_ff.sp_syms + 64'h1 >= i_cfg.sp_window) begin
				nxt_st.sp_syms = '0;
				nxt_st.sp.period_errs = '0;
				if (sp_cnt >= i_cfg.sp_thresh) begin
					nxt_st.evt[2] = 1'b1;
					nxt_st.sp.stamp = now;
					nxt_st.sp.events = st_ff.sp.events + 32'h0000_0001;
				end
			end else begin
				nxt_st.sp_syms = st_ff.sp_syms + 64'h1;
			end
		end

		// a second is errored if any frame error fell in it
		if (i_frame_err) begin
			nxt_st.sec_err = 1'b1;
		end
		if (tick) begin
			if (sec_end) begin
				nxt_st.sec_ticks = '0;
				nxt_st.sec_err = 1'b0;
				if (sec_bad) begin
					nxt_st.es.total_errs = st_ff.es.total_errs
						+ 32'h0000_0001;
				end
			end else begin
				nxt_st.sec_ticks = st_ff.sec_ticks + 4'h1;
			end
			// summary window in ticks; zero window closes on every tick
			if (st_ff.es_ticks + 16'h0001 >= i_cfg.es_window) begin
				nxt_st.es_ticks = '0;
				nxt_st.es.period_errs = '0;
				if (es_cnt >= i_cfg.es_thresh) begin
					nxt_st.evt[3] = 1'b1;
					nxt_st.es.stamp = now;
					nxt_st.es.events = st_ff.es.events + 32'h0000_0001;
				end
			end else begin
				nxt_st.es_ticks = st_ff.es_ticks + 16'h0001;
			end
		end

		// peer report latched whole; its sequence counts remote events
		if (i_remote_valid) begin
			nxt_st.rem = i_remote;
		end

		// clear wins over every count in the same cycle
		if (i_oam_reset || i_clear) begin
			nxt_st = '0;
		end
		// effective window stays outside the clear so a clear never zeroes it
		nxt_st.win = ef_win;
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// every output straight from the state register
	assign o_ef = st_ff.ef;
	assign o_fp = st_ff.fp;
	assign o_sp = st_ff.sp;
	assign o_es = st_ff.es;
	assign o_event = st_ff.evt;
	assign o_remote = st_ff.rem;
	assign o_ef_window = st_ff.win;
endmodule : loem_monitor

// *** loem_monitor_chk.sv ***
`timescale 1ns/1ns
module loem_monitor_chk
	import loem_pkg::*;
#(
	parameter int TICK_CYC = 10
) (
	// clock, reset and controls
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_oam_reset,
	input wire logic i_clear,
	input wire logic i_frame_err,
	input wire logic i_symbol_err,
	input wire loem_cfg_s i_cfg,
	input wire logic i_remote_valid,
	input wire loem_report_s i_remote,
	// observed state
	input wire loem_frame_stat_s o_ef,
	input wire loem_frame_stat_s o_fp,
	input wire loem_sym_stat_s o_sp,
	input wire loem_sec_stat_s o_es,
	input wire logic [15:0] o_ef_window,
	input wire logic [3:0] o_event,
	input wire loem_report_s o_remote
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// counts may only move in a cycle with no clear, clear wins
	sequence s_run;
		!i_clear && !i_oam_reset;
	endsequence
	chk_ef_total: assert property (s_run |=> o_ef.total_errs ==
		$past(o_ef.total_errs) + $past(i_frame_err)) else $error("ef total");
	chk_fp_total: assert property (s_run |=> o_fp.total_errs ==
		$past(o_fp.total_errs) + $past(i_frame_err)) else $error("fp total");
	chk_sym_total: assert property (s_run |=> o_sp.total_errs ==
		$past(o_sp.total_errs) + $past(i_symbol_err)) else $error("sp total");
	chk_clear_all: assert property ((i_clear || i_oam_reset) |=>
		o_ef.events == 0 && o_fp.total_errs == 0 && o_sp.events == 0 &&
		o_es.total_errs == 0) else $error("clear missed");
	chk_remote_take: assert property (s_run ##0 i_remote_valid |=>
		o_remote == $past(i_remote)) else $error("remote not latched");
	chk_fp_restart: assert property (o_event[1] |->
		o_fp.period_errs == 0) else $error("fp period kept");
	chk_sym_events: assert property (o_event[2] |->
		o_sp.events == $past(o_sp.events) + 1) else $error("sp events");
	logic [15:0] want_win;
	// one second to one minute in ticks; the output lags by one edge
	always_comb begin
		want_win = i_cfg.ef_window;
		if (i_cfg.ef_window < 16'h000a) begin
			want_win = 16'h000a;
		end else if (i_cfg.ef_window > 16'h0258) begin
			want_win = 16'h0258;
		end
	end
	chk_win_clamp: assert property (1'b1 |=>
		o_ef_window == $past(want_win)) else $error("window clamp");
endmodule : loem_monitor_chk
bind loem_monitor loem_monitor_chk #(.TICK_CYC(TICK_CYC)) chk_u (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_oam_reset(i_oam_reset),
	.i_clear(i_clear), .i_frame_err(i_frame_err), .i_symbol_err(i_symbol_err),
	.i_cfg(i_cfg), .i_remote_valid(i_remote_valid), .i_remote(i_remote),
	.o_ef(o_ef), .o_fp(o_fp), .o_sp(o_sp), .o_es(o_es),
	.o_ef_window(o_ef_window), .o_event(o_event), .o_remote(o_remote));

// *** loem_peer.sv ***
`timescale 1ns/1ns
module loem_peer
	import loem_pkg::*;
(
	// clock and send request
	input wire logic i_clock,
	input wire logic i_send,
	// report towards the monitor
	output logic o_valid,
	output loem_report_s o_rep,
	output loem_report_s o_sent
);
	loem_report_s fresh;
	initial begin
		o_valid = 1'b0;
		o_rep = '0;
		o_sent = '0;
	end
	// one-cycle report; after it the lines toggle so stale data cannot pass
	always @(posedge i_clock) begin
		o_valid <= i_send;
		if (i_send) begin
			for (int k = 0; k < $bits(loem_report_s) / 32; k++) begin
				fresh[k*32+:32] = $urandom;
			end
			o_sent <= fresh;
			o_rep <= fresh;
		end else begin
			o_rep <= ~o_rep;
		end
	end
endmodule : loem_peer

// *** loem_monitor_test.sv ***
`timescale 1ns/1ns
module loem_monitor_test
	import loem_pkg::*;
;
	localparam int TICK_CYC = 10;
	// stimulus and observation
	logic clk = 0, rst_b = 0, clr = 0, orst = 0, frx = 0, ferr = 0;
	logic srx = 0, serr = 0, send = 0, rv;
	loem_cfg_s cfg = '1;
	loem_report_s rrep, sent, rem;
	loem_frame_stat_s ef, fp;
	loem_sym_stat_s sp;
	loem_sec_stat_s es;
	logic [15:0] win;
	logic [3:0] ev;
	int num_errors = 0, checks_done = 0, k, t, w;
	longint ne = 0, ns = 0;
	longint edges = 0;
	always #4 clk = ~clk;
	// edges since reset release, the base of every expected stamp
	always @(posedge clk) begin
		if (rst_b) begin
			edges <= edges + 1;
		end
	end
	loem_monitor #(.TICK_CYC(TICK_CYC)) dut_u (.i_clock(clk),
		.i_rst_b(rst_b), .i_oam_reset(orst), .i_clear(clr), .i_frame_rx(frx),
		.i_frame_err(ferr), .i_symbol_rx(srx), .i_symbol_err(serr),
		.i_cfg(cfg), .i_remote_valid(rv), .i_remote(rrep), .o_ef(ef),
		.o_fp(fp), .o_sp(sp), .o_es(es), .o_ef_window(win), .o_event(ev),
		.o_remote(rem));
	loem_peer peer_u (.i_clock(clk), .i_send(send), .o_valid(rv),
		.o_rep(rrep), .o_sent(sent));
	// event expected when the window count reaches the threshold
	function automatic logic exp_ev(int n, int thr);
		return n >= thr;
	endfunction : exp_ev
	// whole ticks since reset as the monitor sees them at event edge e
	function automatic logic [15:0] exp_stamp(longint e);
		return 16'((e - 1) / TICK_CYC);
	endfunction : exp_stamp
	task chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task chk_rep(input loem_report_s g, input loem_report_s e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_rep
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task wipe;
		clr = 1;
		cyc(1);
		clr = 0;
	endtask : wipe
	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		#200000;
		num_errors++;
		report_and_stop;
	end
	// main sequence
	initial begin
		void'($urandom(32'hfa5d4f4a));
		cyc(2);
		rst_b = 1;
		chk(ef.total_errs, 0);
		for (int i = 0; i < 400; i++) begin
			{frx, ferr, srx, serr} = 4'($urandom);
			ne += ferr;
			ns += serr;
			cyc(1);
		end
		{frx, ferr, srx, serr} = '0;
		chk(ef.total_errs, ne);
		chk(fp.total_errs, ne);
		chk(sp.total_errs, ns);
		// no window has closed yet, so the period counts match the totals
		chk(ef.period_errs, ne);
		chk(fp.period_errs, ne);
		chk(sp.period_errs, ns);
		orst = 1;
		cyc(1);
		orst = 0;
		chk(fp.total_errs, 0);
		$display("random traffic done");
		// threshold corners: zero, exactly met, missed by one
		for (int c = 0; c < 6; c++) begin
			w = 2 + $urandom % 8;
			k = $urandom % (w + 1);
			t = c == 0 ? 0 : c == 1 ? k : c == 2 ? k + 1 : $urandom % (w + 1);
			cfg.fp_window = w;
			cfg.fp_thresh = t;
			cfg.sp_window = w;
			cfg.sp_thresh = t;
			wipe;
			for (int i = 0; i < w; i++) begin
				{frx, srx} = 2'b11;
				ferr = i < k;
				serr = ferr;
				cyc(1);
			end
			{frx, ferr, srx, serr} = '0;
			chk(ev[1], exp_ev(k, t));
			chk(fp.events, exp_ev(k, t));
			chk(ev[2], exp_ev(k, t));
			chk(sp.events, exp_ev(k, t));
			chk(fp.period_errs, 0);
			chk(sp.total_errs, k);
		end
		$display("window tests done");
		// a too-short window clamps up to ten ticks, zero threshold always fires
		cfg.ef_window = 16'h0001;
		cfg.ef_thresh = 0;
		wipe;
		chk(win, 16'h000a);
		cyc(1050);
		chk(ef.events, 10);
		// default threshold: quiet windows stay silent, one error fires
		cfg.ef_thresh = 32'h0000_0001;
		wipe;
		cyc(250);
		chk(ef.events, 0);
		ferr = 1;
		cyc(1);
		ferr = 0;
		chk(ef.period_errs, 1);
		cyc(100);
		chk(ef.events, 1);
		cfg.ef_window = 16'hffff;
		cyc(1);
		chk(win, 16'h0258);
		$display("frame window done");
		// three-second summary window, errors in seconds one and three
		cfg.es_window = 16'h001e;
		cfg.es_thresh = 16'h0002;
		wipe;
		ferr = 1;
		cyc(1);
		ferr = 0;
		cyc(249);
		chk(es.period_errs, 1);
		chk(es.total_errs, 1);
		chk(es.events, 0);
		ferr = 1;
		cyc(1);
		ferr = 0;
		k = 0;
		while (!ev[3] && k < 100) begin
			cyc(1);
			k++;
		end
		chk(ev[3], 1);
		chk(es.stamp, exp_stamp(edges));
		chk(es.events, 1);
		chk(es.total_errs, 2);
		chk(es.period_errs, 0);
		$display("errored seconds done");
		send = 1;
		cyc(1);
		send = 0;
		cyc(2);
		chk_rep(rem, sent);
		$display("remote report done");
		report_and_stop;
	end
endmodule : loem_monitor_test
